/* File: src/cgr_flag_alu.sv */
// Flag generator: derives H, N, Z, V, C from an add/subtract at byte, word or long size.
// Assumes operands arrive right-aligned in the low bits; upper bits are ignored per size.
`timescale 1ns/10ps
`default_nettype none
module cgr_flag_alu
  import cgr_pkg::*;
(
  input wire logic [31:0] a_in,
  input wire logic [31:0] b_in,
  input wire logic sub_in,
  input wire logic cin_in,
  input wire cgr_size_e size_in,
  output logic [31:0] res_out,
  output logic h_out,
  output logic n_out,
  output logic z_out,
  output logic v_out,
  output logic c_out
);
  wire [31:0] b_eff = sub_in ? ~b_in : b_in;
  wire cin_eff = sub_in ? ~cin_in : cin_in;
  wire [32:0] sum = {1'b0, a_in} + {1'b0, b_eff} + {32'h0, cin_eff};
  // Carry into bit k is a^b^sum at bit k
  wire [31:0] cin_vec = a_in ^ b_eff ^ sum[31:0];
  wire [32:0] cout_vec = {sum[32], cin_vec[31:0]};
  logic [4:0] hpos;
  logic [5:0] msb;
  always_comb begin
    case (size_in)
      CGR_SZ_BYTE: begin
        hpos = 5'(CGR_HC_B + 1);
        msb = 6'd7;
      end
      CGR_SZ_WORD: begin
        hpos = 5'(CGR_HC_W + 1);
        msb = 6'd15;
      end
      default: begin
        hpos = 5'(CGR_HC_L + 1);
        msb = 6'd31;
      end
    endcase
  end
  wire [31:0] mask = (msb == 6'd31) ? 32'hFFFFFFFF : ((32'h1 << (msb + 6'd1)) - 32'h1);
  wire carry_hi = cout_vec[msb + 6'd1];
  wire carry_msb = cin_vec[msb[4:0]];
  // Carry/borrow out of the half-carry bit; borrow is the inverted carry
  assign h_out = cin_vec[hpos] ^ sub_in; // RL15 RL16 RL17
  assign n_out = sum[msb[4:0]]; // RL18
  assign z_out = ((sum[31:0] & mask) == 32'h0); // RL19
  assign v_out = carry_hi ^ carry_msb; // RL20
  assign c_out = carry_hi ^ sub_in; // RL21
  assign res_out = sum[31:0] & mask;
endmodule : cgr_flag_alu
`default_nettype wire

/* File: src/cgr_pkg.sv */
// Package for the CPU architectural register file: widths, field positions, access codes.
// Assumes the datapath, decoder and exception unit share these definitions.
package cgr_pkg;
  localparam int CGR_NREG = 8;
  localparam int CGR_DW = 32;
  localparam int CGR_PCW = 24;
  localparam int CGR_SP_IDX = 7;
  localparam logic [2:0] CGR_SP_SEL = 3'h7;
  // Flag positions
  localparam int CGR_F_I = 7;
  localparam int CGR_F_USR_HI = 6;
  localparam int CGR_F_H = 5;
  localparam int CGR_F_U = 4;
  localparam int CGR_F_N = 3;
  localparam int CGR_F_Z = 2;
  localparam int CGR_F_V = 1;
  localparam int CGR_F_C = 0;
  // Half-carry bit positions per operand size
  localparam int CGR_HC_B = 3;
  localparam int CGR_HC_W = 11;
  localparam int CGR_HC_L = 27;
  // Value of the mask bit after reset and on exception entry
  localparam logic CGR_MASK_RST = 1'b1;
  localparam logic [7:0] CGR_FLAGS_RST = 8'h80;
  localparam logic [23:0] CGR_PC_RST = 24'h000000;

  typedef enum logic [2:0] {
    CGR_W_NONE = 3'h0,
    CGR_W_LOW_BYTE = 3'h1,
    CGR_W_HIGH_BYTE = 3'h2,
    CGR_W_LOW_HALF = 3'h3,
    CGR_W_EXT_HALF = 3'h4,
    CGR_W_FULL = 3'h5
  } cgr_width_e;

  typedef enum logic [2:0] {
    CGR_C_NONE = 3'h0,
    CGR_C_LOAD = 3'h1,
    CGR_C_AND = 3'h2,
    CGR_C_OR = 3'h3,
    CGR_C_XOR = 3'h4,
    CGR_C_ALU = 3'h5
  } cgr_fop_e;

  typedef enum logic [1:0] {
    CGR_SZ_BYTE = 2'h0,
    CGR_SZ_WORD = 2'h1,
    CGR_SZ_LONG = 2'h2
  } cgr_size_e;

  typedef struct packed {
    cgr_width_e width;
    logic [2:0] sel;
    logic [31:0] data;
  } cgr_gpr_req_s;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cgr_cond_s;
endpackage : cgr_pkg

/* File: src/cgr_regfile.sv */
// CPU architectural state: eight general registers, program counter, condition flags.
// Assumes the decoder supplies width selects per port and the exception unit its strobes.
// Overview of operation
// RL1: Eight identical 32-bit general registers, usable for addresses or data.
// RL2: Each register splits into independent extended and low 16-bit halves.
// RL3: Low half splits into separate high-byte and low-byte registers.
// RL4: Each port picks its own access width per instruction.
// RL5: Register 7 doubles as stack pointer for exceptions, calls and returns.
// RL6: A 24-bit program counter holds the next instruction address.
// RL7: Fetch address forces program counter bit 0 to zero.
// RL8: Reset exception loads program counter from the reset vector.
// RL9: Reset exception sets mask bit; other flag bits stay uninitialised (reset here loads them with zero).
// RL10: Flags load, store, AND, OR, XOR with immediate; some ops keep them.
// RL11: N, Z, V, C feed the conditional branch logic.
// RL12: Mask bit 7 blocks maskable interrupts; non-maskable always accepted.
// RL13: Every exception sequence start sets the mask bit.
// RL14: User bits 6 and 4 change only via flag instructions.
// RL15: Byte arithmetic sets half-carry from bit 3 carry or borrow.
// RL16: Word arithmetic sets half-carry from bit 11 carry or borrow.
// RL17: Longword arithmetic sets half-carry from bit 27 carry or borrow.
// RL18: Negative flag takes the result sign bit.
// RL19: Zero flag set for zero result, cleared otherwise.
// RL20: Overflow flag set on arithmetic overflow, cleared otherwise.
// RL21: Carry flag from add carry, subtract borrow, or shift carry out.
// RL22: Bit-manipulation ops use carry flag as single-bit accumulator.
// RL23: Partial writes change only the addressed portion of a register.
// RL24: Reset leaves general register contents untouched.
`timescale 1ns/10ps
`default_nettype none
module cgr_regfile
  import cgr_pkg::*;
#(
  parameter int NREG = CGR_NREG
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // General register write port and two read ports
  input wire cgr_gpr_req_s wr_req_in,
  input wire logic [2:0] rd_a_sel_in,
  input wire cgr_width_e rd_a_width_in,
  input wire logic [2:0] rd_b_sel_in,
  input wire cgr_width_e rd_b_width_in,
  output logic [31:0] rd_a_data_out,
  output logic [31:0] rd_b_data_out,
  // Stack pointer implicit port
  input wire logic sp_wr_in,
  input wire logic [31:0] sp_data_in,
  output logic [31:0] stack_pointer_out,
  // Program counter
  input wire logic pc_load_in,
  input wire logic [23:0] pc_data_in,
  input wire logic pc_inc_in,
  input wire logic reset_vec_valid_in,
  input wire logic [23:0] reset_vec_in,
  output logic [23:0] program_counter_out,
  output logic [23:0] fetch_addr_out,
  // Condition flags
  input wire cgr_fop_e flag_op_in,
  input wire logic [7:0] flag_imm_in,
  input wire logic exc_start_in,
  output logic [7:0] condition_flags_register_out,
  output cgr_cond_s branch_cond_out,
  // Arithmetic flag source
  input wire logic [31:0] alu_a_in,
  input wire logic [31:0] alu_b_in,
  input wire logic alu_sub_in,
  input wire logic alu_cin_in,
  input wire cgr_size_e alu_size_in,
  input wire logic [3:0] alu_keep_in,
  output logic [31:0] alu_res_out,
  // Shift carry and bit accumulator
  input wire logic shift_c_valid_in,
  input wire logic shift_c_in,
  input wire logic bit_acc_wr_in,
  input wire logic bit_acc_in,
  output logic bit_acc_out,
  // Interrupt gating
  input wire logic irq_req_in,
  input wire logic nmi_req_in,
  output logic irq_take_out,
  output logic nmi_take_out
);
  logic [31:0] gpr_ff [NREG];
  logic [23:0] pc_ff;
  logic [7:0] flags_ff;
  logic [7:0] nxt_flags;
  logic [23:0] nxt_pc;

  function automatic logic [31:0] rd_view(input logic [31:0] r, input cgr_width_e w);
    case (w)
      CGR_W_LOW_BYTE: rd_view = {24'h0, r[7:0]};
      CGR_W_HIGH_BYTE: rd_view = {24'h0, r[15:8]};
      CGR_W_LOW_HALF: rd_view = {16'h0, r[15:0]};
      CGR_W_EXT_HALF: rd_view = {16'h0, r[31:16]};
      CGR_W_FULL: rd_view = r;
      default: rd_view = 32'h0;
    endcase
  endfunction : rd_view

  function automatic logic [31:0] merge(input logic [31:0] r, input logic [31:0] d,
                                        input cgr_width_e w);
    case (w)
      CGR_W_LOW_BYTE: merge = {r[31:8], d[7:0]};
      CGR_W_HIGH_BYTE: merge = {r[31:16], d[7:0], r[7:0]};
      CGR_W_LOW_HALF: merge = {r[31:16], d[15:0]};
      CGR_W_EXT_HALF: merge = {d[15:0], r[15:0]};
      CGR_W_FULL: merge = d;
      default: merge = r;
    endcase
  endfunction : merge

  // General registers carry no reset so that reset leaves their contents alone
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_gpr
      wire wr_hit = (wr_req_in.width != CGR_W_NONE) && (wr_req_in.sel == 3'(gi));
      wire sp_hit = sp_wr_in && (gi == CGR_SP_IDX);
      wire [31:0] nxt_gpr = sp_hit ? sp_data_in :
                            wr_hit ? merge(gpr_ff[gi], wr_req_in.data, wr_req_in.width) :
                            gpr_ff[gi]; // RL2 RL3 RL23
      always_ff @(posedge clk_sys_in) begin // RL1 RL24
        gpr_ff[gi] <= nxt_gpr;
      end
    end
  endgenerate

  // Each read port decodes its own width, independently of the other
  assign rd_a_data_out = rd_view(gpr_ff[rd_a_sel_in], rd_a_width_in); // RL4
  assign rd_b_data_out = rd_view(gpr_ff[rd_b_sel_in], rd_b_width_in); // RL4
  assign stack_pointer_out = gpr_ff[CGR_SP_IDX]; // RL5

  // Program counter: reset vector load has priority over branch load and increment
  always_comb begin
    nxt_pc = pc_ff;
    if (reset_vec_valid_in) begin
      nxt_pc = reset_vec_in; // RL8
    end else if (pc_load_in) begin
      nxt_pc = pc_data_in;
    end else if (pc_inc_in) begin
      nxt_pc = pc_ff + 24'h000002;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pc_ff <= CGR_PC_RST;
    end else begin
      pc_ff <= nxt_pc; // RL6
    end
  end
  assign program_counter_out = pc_ff;
  assign fetch_addr_out = {pc_ff[23:1], 1'b0}; // RL7

  // Arithmetic flags
  logic a_h, a_n, a_z, a_v, a_c;
  cgr_flag_alu u_alu (
    .a_in(alu_a_in),
    .b_in(alu_b_in),
    .sub_in(alu_sub_in),
    .cin_in(alu_cin_in),
    .size_in(alu_size_in),
    .res_out(alu_res_out),
    .h_out(a_h),
    .n_out(a_n),
    .z_out(a_z),
    .v_out(a_v),
    .c_out(a_c)
  );

  // alu_keep_in bits {N,Z,V,C} hold flags that an instruction leaves unchanged
  wire [7:0] alu_flags = {flags_ff[CGR_F_I], flags_ff[CGR_F_USR_HI], a_h, flags_ff[CGR_F_U],
                          alu_keep_in[3] ? flags_ff[CGR_F_N] : a_n,
                          alu_keep_in[2] ? flags_ff[CGR_F_Z] : a_z,
                          alu_keep_in[1] ? flags_ff[CGR_F_V] : a_v,
                          alu_keep_in[0] ? flags_ff[CGR_F_C] : a_c}; // RL10 RL14

  // User bits are reachable only through the load/and/or/xor paths below
  always_comb begin
    case (flag_op_in)
      CGR_C_LOAD: nxt_flags = flag_imm_in; // RL10 RL14
      CGR_C_AND: nxt_flags = flags_ff & flag_imm_in; // RL10
      CGR_C_OR: nxt_flags = flags_ff | flag_imm_in; // RL10
      CGR_C_XOR: nxt_flags = flags_ff ^ flag_imm_in; // RL10
      CGR_C_ALU: nxt_flags = alu_flags; // RL15 RL16 RL17 RL18 RL19 RL20
      default: nxt_flags = flags_ff;
    endcase
    if (shift_c_valid_in) begin
      nxt_flags[CGR_F_C] = shift_c_in; // RL21
    end
    if (bit_acc_wr_in) begin
      nxt_flags[CGR_F_C] = bit_acc_in; // RL22
    end
    // Exception entry wins over any mask bit update in the same cycle
    if (exc_start_in) begin
      nxt_flags[CGR_F_I] = CGR_MASK_RST; // RL13
    end
  end

  // Only the mask bit has a defined reset value; zeros elsewhere avoid X in simulation
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      flags_ff <= CGR_FLAGS_RST; // RL9
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign condition_flags_register_out = flags_ff; // RL10
  assign branch_cond_out = '{n: flags_ff[CGR_F_N], z: flags_ff[CGR_F_Z],
                             v: flags_ff[CGR_F_V], c: flags_ff[CGR_F_C]}; // RL11
  assign bit_acc_out = flags_ff[CGR_F_C]; // RL22
  assign irq_take_out = irq_req_in && !flags_ff[CGR_F_I]; // RL12
  assign nmi_take_out = nmi_req_in; // RL12

  // Assertions
  AST_MASK_BLOCKS: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL12
    flags_ff[CGR_F_I] |-> !irq_take_out)
    else $error("maskable interrupt taken while masked");
  AST_NMI_PASSES: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL12
    nmi_req_in |-> nmi_take_out)
    else $error("non-maskable interrupt not taken");
  AST_EXC_MASK: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL13
    exc_start_in |=> flags_ff[CGR_F_I])
    else $error("mask bit not set after exception start");
  AST_RESET_MASK: assert property (@(posedge clk_sys_in) // RL9
    !rstn_in |=> flags_ff[CGR_F_I])
    else $error("mask bit not set after reset");
  AST_FETCH_EVEN: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL7
    fetch_addr_out[0] == 1'b0 && fetch_addr_out[23:1] == program_counter_out[23:1])
    else $error("fetch address not even copy of counter");
  AST_VEC_LOAD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL8
    reset_vec_valid_in |=> program_counter_out == $past(reset_vec_in))
    else $error("counter not loaded from reset vector");
  AST_PC_INC: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL6
    pc_inc_in && !pc_load_in && !reset_vec_valid_in |=>
    program_counter_out == $past(program_counter_out) + 24'h000002)
    else $error("counter did not advance by one word");
  AST_LOW_BYTE_ONLY: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL23
    wr_req_in.width == CGR_W_LOW_BYTE && !sp_wr_in |=>
    gpr_ff[$past(wr_req_in.sel)][31:8] == $past(gpr_ff[wr_req_in.sel][31:8]))
    else $error("byte write disturbed upper bits");
  AST_FLAGS_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL14
    flag_op_in != CGR_C_LOAD && flag_op_in != CGR_C_AND && flag_op_in != CGR_C_OR &&
    flag_op_in != CGR_C_XOR |=> flags_ff[CGR_F_USR_HI] == $past(flags_ff[CGR_F_USR_HI]) &&
    flags_ff[CGR_F_U] == $past(flags_ff[CGR_F_U]))
    else $error("user bit changed outside flag instructions");
  AST_ZERO_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rstn_in) // RL19
    flag_op_in == CGR_C_ALU && !alu_keep_in[2] |=> flags_ff[CGR_F_Z] == ($past(alu_res_out) == 32'h0))
    else $error("zero flag does not match result");
  COV_EXC: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) exc_start_in);
  COV_IRQ: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) irq_take_out);
  COV_XOR: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) flag_op_in == CGR_C_XOR);
  COV_SP: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) sp_wr_in);
endmodule : cgr_regfile
`default_nettype wire

/* File: test/test_cpu_gpr_pc_flag_registers.sv */
// Self-checking bench for the architectural register file: general registers, counter, flags.
// Assumes cgr_pkg and cgr_regfile are compiled first; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
module test_cpu_gpr_pc_flag_registers;
  import cgr_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  cgr_gpr_req_s wr_req = '0;
  logic [2:0] sa = 3'h0, sb = 3'h0;
  cgr_width_e wa = CGR_W_NONE, wb = CGR_W_NONE;
  logic [31:0] da, db, sp_q, sp_d = 32'h0, alu_a = 32'h0, alu_b = 32'h0, alu_res;
  logic sp_wr = 1'b0, pc_ld = 1'b0, pc_inc = 1'b0, rv_vld = 1'b0, exc = 1'b0;
  logic [23:0] pc_d = 24'h0, rv = 24'h0, pc_q, fetch;
  cgr_fop_e fop = CGR_C_NONE;
  logic [7:0] imm = 8'h00, flags;
  cgr_cond_s bcond;
  logic alu_sub = 1'b0, alu_cin = 1'b0, sh_v = 1'b0, sh_c = 1'b0, ba_wr = 1'b0, ba_d = 1'b0;
  cgr_size_e alu_sz = CGR_SZ_BYTE;
  logic [3:0] keep = 4'h0;
  logic acc_q, irq = 1'b0, nmi = 1'b0, irq_take, nmi_take;
  int error_cnt = 0;
  int tests_run = 0;
  int cycles = 0;

  cgr_regfile dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .wr_req_in(wr_req),
    .rd_a_sel_in(sa), .rd_a_width_in(wa), .rd_b_sel_in(sb), .rd_b_width_in(wb),
    .rd_a_data_out(da), .rd_b_data_out(db), .sp_wr_in(sp_wr), .sp_data_in(sp_d),
    .stack_pointer_out(sp_q), .pc_load_in(pc_ld), .pc_data_in(pc_d), .pc_inc_in(pc_inc),
    .reset_vec_valid_in(rv_vld), .reset_vec_in(rv), .program_counter_out(pc_q),
    .fetch_addr_out(fetch), .flag_op_in(fop), .flag_imm_in(imm), .exc_start_in(exc),
    .condition_flags_register_out(flags), .branch_cond_out(bcond), .alu_a_in(alu_a),
    .alu_b_in(alu_b), .alu_sub_in(alu_sub), .alu_cin_in(alu_cin), .alu_size_in(alu_sz),
    .alu_keep_in(keep), .alu_res_out(alu_res), .shift_c_valid_in(sh_v), .shift_c_in(sh_c),
    .bit_acc_wr_in(ba_wr), .bit_acc_in(ba_d), .bit_acc_out(acc_q), .irq_req_in(irq),
    .nmi_req_in(nmi), .irq_take_out(irq_take), .nmi_take_out(nmi_take));

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic close_out();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Generous ceiling: the sequence needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input cgr_width_e w, input logic [2:0] s, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr_req <= '{width: w, sel: s, data: d};
    @(posedge clk_sys_in);
    wr_req.width <= CGR_W_NONE;
  endtask : wr

  task automatic rd2(input logic [2:0] s1, input cgr_width_e w1, input logic [31:0] e1,
                     input logic [2:0] s2, input cgr_width_e w2, input logic [31:0] e2);
    @(posedge clk_sys_in);
    sa <= s1;
    wa <= w1;
    sb <= s2;
    wb <= w2;
    @(negedge clk_sys_in);
    chk(da, e1);
    chk(db, e2);
  endtask : rd2

  task automatic flg(input cgr_fop_e op, input logic [7:0] v, input logic [7:0] exp);
    @(posedge clk_sys_in);
    fop <= op;
    imm <= v;
    @(posedge clk_sys_in);
    fop <= CGR_C_NONE;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, {24'h0, exp});
  endtask : flg

  // Flags are preloaded with 0x50, so I stays 0 and both user bits stay 1
  task automatic alu(input cgr_size_e z, input logic s, input logic [31:0] a,
                     input logic [31:0] b, input logic [31:0] er, input logic [4:0] hnzvc);
    @(posedge clk_sys_in);
    alu_sz <= z;
    alu_sub <= s;
    alu_a <= a;
    alu_b <= b;
    fop <= CGR_C_ALU;
    @(negedge clk_sys_in);
    chk(alu_res, er);
    @(posedge clk_sys_in);
    fop <= CGR_C_NONE;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, {24'h0, 2'b01, hnzvc[4], 1'b1, hnzvc[3:0]});
    chk({28'h0, bcond}, {28'h0, hnzvc[3:0]});
  endtask : alu

  initial begin
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, {24'h0, CGR_FLAGS_RST});
    for (int i = 0; i < 8; i++) begin
      wr(CGR_W_FULL, 3'(i), 32'h1111_1111 * (i + 1));
    end
    for (int i = 0; i < 8; i++) begin
      rd2(3'(i), CGR_W_FULL, 32'h1111_1111 * (i + 1), 3'(i), CGR_W_LOW_BYTE, 32'h11 * (i + 1));
    end
    wr(CGR_W_LOW_BYTE, 3'h2, 32'hFFFF_FFAB);
    rd2(3'h2, CGR_W_FULL, 32'h3333_33AB, 3'h2, CGR_W_HIGH_BYTE, 32'h33);
    wr(CGR_W_HIGH_BYTE, 3'h2, 32'hFFFF_FFCD);
    rd2(3'h2, CGR_W_FULL, 32'h3333_CDAB, 3'h1, CGR_W_EXT_HALF, 32'h2222);
    wr(CGR_W_LOW_HALF, 3'h2, 32'hFFFF_5566);
    rd2(3'h2, CGR_W_FULL, 32'h3333_5566, 3'h2, CGR_W_LOW_HALF, 32'h5566);
    wr(CGR_W_EXT_HALF, 3'h2, 32'hFFFF_7788);
    rd2(3'h2, CGR_W_EXT_HALF, 32'h7788, 3'h2, CGR_W_FULL, 32'h7788_5566);
    rd2(3'h1, CGR_W_NONE, 32'h0, 3'h1, CGR_W_LOW_HALF, 32'h2222);
    @(negedge clk_sys_in);
    chk(sp_q, 32'h8888_8888);
    // Implicit push and a decoder write on register 7 in one cycle: implicit port wins
    @(posedge clk_sys_in);
    sp_wr <= 1'b1;
    sp_d <= 32'h00FF_FFF0;
    wr_req <= '{width: CGR_W_FULL, sel: 3'h7, data: 32'h1234_5678};
    @(posedge clk_sys_in);
    sp_wr <= 1'b0;
    wr_req.width <= CGR_W_NONE;
    rd2(3'h7, CGR_W_FULL, 32'h00FF_FFF0, 3'h7, CGR_W_LOW_BYTE, 32'hF0);
    chk(sp_q, 32'h00FF_FFF0);
    // Counter: load odd, fetch even, then step, then vector beats load
    @(posedge clk_sys_in);
    pc_ld <= 1'b1;
    pc_d <= 24'h12_3457;
    @(posedge clk_sys_in);
    pc_ld <= 1'b0;
    @(negedge clk_sys_in);
    chk({8'h0, pc_q}, 32'h12_3457);
    chk({8'h0, fetch}, 32'h12_3456);
    @(posedge clk_sys_in);
    pc_inc <= 1'b1;
    @(posedge clk_sys_in);
    pc_inc <= 1'b0;
    @(negedge clk_sys_in);
    chk({8'h0, pc_q}, 32'h12_3459);
    @(posedge clk_sys_in);
    rv_vld <= 1'b1;
    rv <= 24'hAB_CDEF;
    pc_ld <= 1'b1;
    @(posedge clk_sys_in);
    rv_vld <= 1'b0;
    pc_ld <= 1'b0;
    @(negedge clk_sys_in);
    chk({8'h0, pc_q}, 32'hAB_CDEF);
    chk({8'h0, fetch}, 32'hAB_CDEE);
    // Flag instructions, user bits included
    flg(CGR_C_LOAD, 8'h50, 8'h50);
    flg(CGR_C_AND, 8'h1F, 8'h10);
    flg(CGR_C_OR, 8'h63, 8'h73);
    flg(CGR_C_XOR, 8'hFF, 8'h8C);
    flg(CGR_C_LOAD, 8'h50, 8'h50);
    alu(CGR_SZ_BYTE, 1'b0, 32'h0F, 32'h01, 32'h10, 5'b10000);
    alu(CGR_SZ_BYTE, 1'b0, 32'h7F, 32'h01, 32'h80, 5'b11010);
    alu(CGR_SZ_BYTE, 1'b0, 32'hFF, 32'h01, 32'h00, 5'b10101);
    alu(CGR_SZ_BYTE, 1'b1, 32'h00, 32'h01, 32'hFF, 5'b11001);
    alu(CGR_SZ_BYTE, 1'b0, 32'h11, 32'h22, 32'h33, 5'b00000);
    alu(CGR_SZ_WORD, 1'b0, 32'h0FFF, 32'h0001, 32'h1000, 5'b10000);
    alu(CGR_SZ_WORD, 1'b1, 32'h8000, 32'h0001, 32'h7FFF, 5'b10010);
    alu(CGR_SZ_LONG, 1'b0, 32'h0FFF_FFFF, 32'h1, 32'h1000_0000, 5'b10000);
    alu(CGR_SZ_LONG, 1'b0, 32'hFFFF_FFFF, 32'h1, 32'h0, 5'b10101);
    // Add with extend that leaves Z and C alone: flags were 0x75, N and V are updated
    @(posedge clk_sys_in);
    alu_sz <= CGR_SZ_BYTE;
    alu_a <= 32'h7E;
    alu_b <= 32'h01;
    alu_cin <= 1'b1;
    keep <= 4'h5;
    fop <= CGR_C_ALU;
    @(negedge clk_sys_in);
    chk(alu_res, 32'h80);
    @(posedge clk_sys_in);
    fop <= CGR_C_NONE;
    alu_cin <= 1'b0;
    keep <= 4'h0;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, 32'h7F);
    chk({28'h0, bcond}, 32'hF);
    // Shift carry, then bit accumulator winning over it
    @(posedge clk_sys_in);
    sh_v <= 1'b0;
    ba_wr <= 1'b1;
    ba_d <= 1'b0;
    @(posedge clk_sys_in);
    ba_wr <= 1'b0;
    sh_v <= 1'b1;
    sh_c <= 1'b1;
    @(posedge clk_sys_in);
    ba_wr <= 1'b1;
    ba_d <= 1'b0;
    @(negedge clk_sys_in);
    chk({31'h0, acc_q}, 32'h1);
    chk({31'h0, bcond.c}, 32'h1);
    @(posedge clk_sys_in);
    ba_wr <= 1'b0;
    sh_v <= 1'b0;
    @(negedge clk_sys_in);
    chk({31'h0, acc_q}, 32'h0);
    // Interrupt gating, then exception entry overriding a software clear
    flg(CGR_C_LOAD, 8'h00, 8'h00);
    @(posedge clk_sys_in);
    irq <= 1'b1;
    nmi <= 1'b1;
    @(negedge clk_sys_in);
    chk({30'h0, irq_take, nmi_take}, 32'h3);
    @(posedge clk_sys_in);
    exc <= 1'b1;
    fop <= CGR_C_LOAD;
    imm <= 8'h01;
    @(posedge clk_sys_in);
    exc <= 1'b0;
    fop <= CGR_C_NONE;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, 32'h81);
    chk({30'h0, irq_take, nmi_take}, 32'h1);
    // Second reset: flags and counter reinitialised, general registers kept
    @(posedge clk_sys_in);
    rstn_in <= 1'b0;
    irq <= 1'b0;
    @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    @(negedge clk_sys_in);
    chk({24'h0, flags}, {24'h0, CGR_FLAGS_RST});
    chk({8'h0, pc_q}, {8'h0, CGR_PC_RST});
    rd2(3'h2, CGR_W_FULL, 32'h7788_5566, 3'h7, CGR_W_FULL, 32'h00FF_FFF0);
    close_out();
  end
endmodule : test_cpu_gpr_pc_flag_registers
`default_nettype wire
